//--- hdl/pbcr_pkg.sv
// Package with register map, field layout, reset values and timing of the control slice
package pbcr_pkg;
	// Register offsets (7-bit address space)
	localparam logic [6:0] ADDR_INT_MASK = 7'h09;
	localparam logic [6:0] ADDR_PWM_CFG = 7'h0a;
	localparam logic [6:0] ADDR_SCRATCH = 7'h0b;
	localparam logic [6:0] ADDR_BRIDGE = 7'h10;

	// Reset values at power-on or soft reset
	localparam logic [15:0] INT_MASK_RST = 16'h0140;
	localparam logic [15:0] PWM_CFG_RST = 16'h0000;
	localparam logic [15:0] SCRATCH_RST = 16'h0000;
	localparam logic [15:0] BRIDGE_RST = 16'h0801;

	// Writable bits and bits kept through a restart
	localparam logic [15:0] INT_MASK_WMASK = 16'h01ff;
	localparam logic [15:0] INT_MASK_KEEP = 16'h01ff;
	localparam logic [15:0] PWM_CFG_WMASK = 16'h7ff7;
	localparam logic [15:0] PWM_CFG_KEEP = 16'h7ff0;

	// Field positions of the generator configuration register
	localparam int RATE_BIT = 14;
	localparam int DUTY_MSB = 13;
	localparam int DUTY_LSB = 4;
	localparam int SEL_MSB = 2;
	localparam int SEL_LSB = 0;

	// Field positions of the general bridge configuration register
	localparam int SYNC_RATE_BIT = 15;
	localparam int THIRD_MAP_BIT = 14;
	localparam int FIRST_MAP_BIT = 13;
	localparam int PUMP_UV_BIT = 12;
	localparam int GATE_LVL_BIT = 11;
	localparam int PUMP_AUTO_BIT = 10;
	localparam int OV_REC_BIT = 9;
	localparam int PRECHG_BIT = 8;

	// Generator count and duty resolution
	localparam int GEN_COUNT = 4;
	localparam int DUTY_W = 10;
	localparam int DUTY_STEPS = 1024;
	localparam int CNT_W = 21;

	// Timing: clock period and the two generator periods in ns
	localparam int CLK_PERIOD_NS = 32'h0000_0005;
	localparam int PERIOD_SLOW_NS = 32'h0098_9680;
	localparam int PERIOD_FAST_NS = 32'h004c_4b40;
	localparam int PERIOD_SLOW_CYC = PERIOD_SLOW_NS / CLK_PERIOD_NS;
	localparam int PERIOD_FAST_CYC = PERIOD_FAST_NS / CLK_PERIOD_NS;

	// Register access request from the serial frame decoder
	typedef struct packed {
		logic valid;
		logic write;
		logic [6:0] addr;
		logic [15:0] wdata;
	} pbcr_req_type;

	// Register read answer
	typedef struct packed {
		logic valid;
		logic [15:0] rdata;
	} pbcr_rsp_type;

	// Decoded bridge driver options
	typedef struct packed {
		logic bridge_sync_rate;
		logic third_input_bridge_map;
		logic first_input_bridge_map;
		logic pump_undervolt_level;
		logic mosfet_gate_level;
		logic pump_stage_auto;
		logic overvolt_recovery;
		logic precharge_step_size;
		logic [7:0] low_bits;
	} pbcr_bridge_type;

	// Half-bridge routing of the two shared PWM inputs, one-hot over half-bridges 1..4
	typedef struct packed {
		logic [3:0] first_input_route;
		logic [3:0] third_input_route;
	} pbcr_route_type;
endpackage

//--- hdl/pbcr_gen.sv
// One internal high-side PWM generator with period-boundary reload
`timescale 1ns/1ps
module pbcr_gen (
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic [pbcr_pkg::CNT_W-1:0] step_slow, // Cycles per duty step, slow rate
	input wire logic [pbcr_pkg::CNT_W-1:0] step_fast, // Cycles per duty step, fast rate
	input wire logic gen_rate_select, // Programmed rate
	input wire logic [pbcr_pkg::DUTY_W-1:0] gen_duty_value, // Programmed duty
	output logic pwm_out // Switch drive level
);
	import pbcr_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [DUTY_W-1:0] phase;
		logic rate;
		logic [DUTY_W-1:0] duty;
		logic out;
	} pbcr_gen_type;

	pbcr_gen_type state_q;
	pbcr_gen_type state_d;
	logic [CNT_W-1:0] step_now;
	logic step_end;

	// Step length follows the rate of the running period
	assign step_now = state_q.rate ? step_fast : step_slow;
	assign step_end = (state_q.cnt >= step_now - CNT_W'(1));

	// Step and phase counting, settings taken only at a period boundary
	always_comb begin
		state_d = state_q;
		if (step_end) begin
			state_d.cnt = '0;
			state_d.phase = state_q.phase + DUTY_W'(1);
			if (state_q.phase == {DUTY_W{1'b1}}) begin
				state_d.rate = gen_rate_select;
				state_d.duty = gen_duty_value;
			end
		end else begin
			state_d.cnt = state_q.cnt + CNT_W'(1);
		end
		if (state_d.duty == {DUTY_W{1'b1}}) begin
			state_d.out = 1'b1;
		end else begin
			state_d.out = (state_d.phase < state_d.duty);
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign pwm_out = state_q.out;
endmodule

//--- hdl/pbcr_top.sv
// Control register slice: interrupt mask, banked PWM generators, scratch word, bridge options
// Operation
// - Power-on loads mask with bits 8, 6
// - Restart clears mask bits 15..9, keeps rest
// - Rate bit 14 picks 100 or 200 Hz
// - Duty 13..4 is n/1024; 0 off, max on
// - Select field 2..0 picks generator one..four
// - Bits 15 and 3 always read zero
// - Config clears on reset; restart clears 15, 3..0
// - New setting valid after one full pulse
// - Scratch cleared only by reset, never used internally
// - Scratch accessible only in normal mode
// - Bit 15 picks bridge sync rate
// - Bit 14 routes third input to bridge 3/4
// - Bit 13 routes first input to bridge 1/2
// - Bit 12 picks pump undervoltage threshold
// - Bit 11 picks logic or normal MOSFET
// - Bit 10 enables automatic pump stage switching
// - Bit 9 enables overvoltage recovery
// - Bit 8 sets precharge adaptation step
// - Bridge register resets to bits 11, 0
`timescale 1ns/1ps
module pbcr_top #(
	parameter logic [pbcr_pkg::CNT_W-1:0] PERIOD_SLOW = pbcr_pkg::CNT_W'(pbcr_pkg::PERIOD_SLOW_CYC),
	parameter logic [pbcr_pkg::CNT_W-1:0] PERIOD_FAST = pbcr_pkg::CNT_W'(pbcr_pkg::PERIOD_FAST_CYC)
) (
	input wire logic clk, // System clock, 200 MHz
	input wire logic rst, // Power-on or soft reset, synchronous
	input wire logic restart, // Restart event, one-cycle pulse
	input wire logic normal_mode, // Device is in normal mode
	input wire pbcr_pkg::pbcr_req_type req, // Register access request
	output pbcr_pkg::pbcr_rsp_type rsp, // Register read answer
	output logic [15:0] int_mask, // Interrupt mask towards interrupt logic
	output pbcr_pkg::pbcr_bridge_type bridge_cfg, // Bridge driver options
	output pbcr_pkg::pbcr_route_type bridge_route, // Half-bridge routing of PWM inputs
	output logic [pbcr_pkg::GEN_COUNT-1:0] hs_pwm // Generator outputs to high-side switches
);
	import pbcr_pkg::*;

	// Whole register state of the slice
	typedef struct packed {
		logic [15:0] int_mask;
		logic [15:0] pwm_cfg;
		logic [GEN_COUNT-1:0] gen_rate;
		logic [GEN_COUNT-1:0][DUTY_W-1:0] gen_duty;
		logic [15:0] scratch;
		logic [15:0] bridge;
		pbcr_rsp_type rsp;
	} pbcr_state_type;

	pbcr_state_type state_q;
	pbcr_state_type state_d;
	logic [CNT_W-1:0] step_slow;
	logic [CNT_W-1:0] step_fast;

	// Write-access test for one register
	function automatic logic is_write(input pbcr_req_type r, input logic [6:0] a);
		is_write = r.valid && r.write && (r.addr == a);
	endfunction

	// Merge write data under a mask of writable bits
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [15:0] m);
		merge = (old & ~m) | (wd & m);
	endfunction

	// Duty step length per rate, never below one cycle
	assign step_slow = (PERIOD_SLOW < CNT_W'(DUTY_STEPS)) ? CNT_W'(1) :
		CNT_W'(PERIOD_SLOW / CNT_W'(DUTY_STEPS));
	assign step_fast = (PERIOD_FAST < CNT_W'(DUTY_STEPS)) ? CNT_W'(1) :
		CNT_W'(PERIOD_FAST / CNT_W'(DUTY_STEPS));

	// Register writes, restart handling and read answer
	always_comb begin
		logic [2:0] sel;
		logic [15:0] cfg_w;
		sel = req.wdata[SEL_MSB:SEL_LSB];
		cfg_w = '0;
		state_d = state_q;
		state_d.rsp.valid = 1'b0;
		state_d.rsp.rdata = state_q.rsp.rdata;

		// Interrupt mask
		if (is_write(req, ADDR_INT_MASK)) begin
			state_d.int_mask = merge(state_q.int_mask, req.wdata, INT_MASK_WMASK);
		end

		// Banked generator configuration
		if (is_write(req, ADDR_PWM_CFG)) begin
			cfg_w = merge(state_q.pwm_cfg, req.wdata, PWM_CFG_WMASK);
			state_d.pwm_cfg = cfg_w;
			if (!sel[2]) begin
				state_d.gen_rate[sel[1:0]] = cfg_w[RATE_BIT];
				state_d.gen_duty[sel[1:0]] = cfg_w[DUTY_MSB:DUTY_LSB];
			end
		end

		// Scratch word, host only and normal mode only
		if (is_write(req, ADDR_SCRATCH) && normal_mode) begin
			state_d.scratch = req.wdata;
		end

		// General bridge configuration
		if (is_write(req, ADDR_BRIDGE)) begin
			state_d.bridge = req.wdata;
		end

		// Restart: partial clear, scratch and bridge untouched
		if (restart) begin
			state_d.int_mask = state_d.int_mask & INT_MASK_KEEP;
			state_d.pwm_cfg = state_d.pwm_cfg & PWM_CFG_KEEP;
		end

		// Read answer, unmapped addresses read zero
		if (req.valid && !req.write) begin
			state_d.rsp.valid = 1'b1;
			case (req.addr)
				ADDR_INT_MASK: state_d.rsp.rdata = state_q.int_mask;
				ADDR_PWM_CFG: state_d.rsp.rdata = state_q.pwm_cfg & PWM_CFG_WMASK;
				ADDR_SCRATCH: state_d.rsp.rdata = normal_mode ? state_q.scratch : 16'h0000;
				ADDR_BRIDGE: state_d.rsp.rdata = state_q.bridge;
				default: state_d.rsp.rdata = 16'h0000;
			endcase
		end
	end

	// State register with power-on or soft reset values
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q.int_mask <= INT_MASK_RST;
			state_q.pwm_cfg <= PWM_CFG_RST;
			state_q.gen_rate <= '0;
			state_q.gen_duty <= '0;
			state_q.scratch <= SCRATCH_RST;
			state_q.bridge <= BRIDGE_RST;
			state_q.rsp <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// Four generators, each fed by its own bank
	genvar g;
	generate
		for (g = 0; g < GEN_COUNT; g++) begin : gen_pwm
			pbcr_gen u_gen (
				.clk(clk),
				.rst(rst),
				.step_slow(step_slow),
				.step_fast(step_fast),
				.gen_rate_select(state_q.gen_rate[g]),
				.gen_duty_value(state_q.gen_duty[g]),
				.pwm_out(hs_pwm[g])
			);
		end
	endgenerate

	// Bridge option fields
	assign bridge_cfg.bridge_sync_rate = state_q.bridge[SYNC_RATE_BIT];
	assign bridge_cfg.third_input_bridge_map = state_q.bridge[THIRD_MAP_BIT];
	assign bridge_cfg.first_input_bridge_map = state_q.bridge[FIRST_MAP_BIT];
	assign bridge_cfg.pump_undervolt_level = state_q.bridge[PUMP_UV_BIT];
	assign bridge_cfg.mosfet_gate_level = state_q.bridge[GATE_LVL_BIT];
	assign bridge_cfg.pump_stage_auto = state_q.bridge[PUMP_AUTO_BIT];
	assign bridge_cfg.overvolt_recovery = state_q.bridge[OV_REC_BIT];
	assign bridge_cfg.precharge_step_size = state_q.bridge[PRECHG_BIT];
	assign bridge_cfg.low_bits = state_q.bridge[7:0];

	// One-hot half-bridge routing of the shared PWM inputs
	assign bridge_route.first_input_route = state_q.bridge[FIRST_MAP_BIT] ? 4'h2 : 4'h1;
	assign bridge_route.third_input_route = state_q.bridge[THIRD_MAP_BIT] ? 4'h8 : 4'h4;

	// Outputs from registers
	assign rsp = state_q.rsp;
	assign int_mask = state_q.int_mask;
endmodule

//--- dv/pbcr_monitor.sv
// Port checker of the control slice
`timescale 1ns/1ps
module pbcr_monitor (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic restart, // Restart pulse
	input wire logic normal_mode, // Mode level
	input wire pbcr_pkg::pbcr_req_type req, // Request
	input wire pbcr_pkg::pbcr_rsp_type rsp, // Answer
	input wire logic [15:0] int_mask, // Mask
	input wire pbcr_pkg::pbcr_bridge_type bridge_cfg, // Bridge options
	input wire pbcr_pkg::pbcr_route_type bridge_route, // Routing
	input wire logic [3:0] hs_pwm // Generator outputs
);
	import pbcr_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Reset values, restart behaviour and reserved mask bits
	property p_mask_por; $fell(rst) |-> int_mask == 16'h0140; endproperty
	a_mask_por: assert property (p_mask_por) else $error("mask reset value");
	property p_mask_keep; restart && !req.valid |=> $stable(int_mask); endproperty
	a_mask_keep: assert property (p_mask_keep) else $error("mask lost on restart");
	property p_mask_res; int_mask[15:9] == 7'h00; endproperty
	a_mask_res: assert property (p_mask_res) else $error("mask reserved bits set");
	property p_pwm_por; $fell(rst) |-> hs_pwm == 4'h0; endproperty
	a_pwm_por: assert property (p_pwm_por) else $error("generator on after reset");
	property p_br_por; $fell(rst) |-> bridge_cfg == 16'h0801; endproperty
	a_br_por: assert property (p_br_por) else $error("bridge reset value");
	// Readback of reserved bits and refused scratch
	property p_cfg_res;
		req.valid && !req.write && req.addr == ADDR_PWM_CFG |=>
			rsp.valid && !rsp.rdata[15] && !rsp.rdata[3];
	endproperty
	a_cfg_res: assert property (p_cfg_res) else $error("reserved bit read");
	property p_scr;
		req.valid && !req.write && req.addr == ADDR_SCRATCH && !normal_mode |=>
			rsp.rdata == 16'h0000;
	endproperty
	a_scr: assert property (p_scr) else $error("scratch read outside mode");
	// Bridge fields and routing
	property p_br_wr;
		req.valid && req.write && req.addr == ADDR_BRIDGE |=>
			bridge_cfg[15:8] == $past(req.wdata[15:8]);
	endproperty
	a_br_wr: assert property (p_br_wr) else $error("bridge write");
	property p_rt3;
		bridge_route.third_input_route == (bridge_cfg.third_input_bridge_map ? 4'h8 : 4'h4);
	endproperty
	a_rt3: assert property (p_rt3) else $error("third input route");
	property p_rt1;
		bridge_route.first_input_route == (bridge_cfg.first_input_bridge_map ? 4'h2 : 4'h1);
	endproperty
	a_rt1: assert property (p_rt1) else $error("first input route");
endmodule
bind pbcr_top pbcr_monitor mon (.clk(clk), .rst(rst), .restart(restart),
	.normal_mode(normal_mode), .req(req), .rsp(rsp), .int_mask(int_mask),
	.bridge_cfg(bridge_cfg), .bridge_route(bridge_route), .hs_pwm(hs_pwm));

//--- dv/pbcr_host.sv
// Host model issuing register requests
`timescale 1ns/1ps
module pbcr_host (
	input wire logic clk, // Clock
	output pbcr_pkg::pbcr_req_type req, // Request
	input wire pbcr_pkg::pbcr_rsp_type rsp // Answer
);
	initial req = '0;
	// Write, held across the taking edge, released lines toggle
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(negedge clk);
		req = {2'b11, a, d};
		@(negedge clk);
		req = {1'b0, ~req[23:0]};
	endtask
	// Read, one-cycle answer taken half a cycle after the taking edge, then release
	task automatic rd(input logic [6:0] a, output logic [16:0] r);
		@(negedge clk);
		req = {2'b10, a, 16'h0000};
		@(negedge clk);
		r = rsp;
		req = {1'b0, ~req[23:0]};
	endtask
endmodule

//--- dv/pbcr_tb_top.sv
// Self-checking bench of the control slice
`timescale 1ns/1ps
module pbcr_tb_top;
	import pbcr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic restart = 1'b0;
	logic normal_mode = 1'b1;
	pbcr_req_type req;
	pbcr_rsp_type rsp;
	logic [15:0] int_mask;
	pbcr_bridge_type bridge_cfg;
	pbcr_route_type bridge_route;
	logic [3:0] hs_pwm;
	logic [16:0] r;
	int n;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;
	// Clock and instances
	always #2.5 clk = ~clk;
	pbcr_top #(.PERIOD_SLOW(21'h0800), .PERIOD_FAST(21'h0400)) dut (.clk(clk), .rst(rst),
		.restart(restart), .normal_mode(normal_mode), .req(req), .rsp(rsp),
		.int_mask(int_mask), .bridge_cfg(bridge_cfg), .bridge_route(bridge_route),
		.hs_pwm(hs_pwm));
	pbcr_host host (.clk(clk), .req(req), .rsp(rsp));
	// Compare and helpers
	task automatic chk(input string s, input logic [16:0] e, input logic [16:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rdc(input string s, input logic [6:0] a, input logic [15:0] e);
		host.rd(a, r);
		chk(s, {1'b1, e}, r);
	endtask
	task automatic pulse_restart();
		@(negedge clk);
		restart = 1'b1;
		@(negedge clk);
		restart = 1'b0;
	endtask
	task automatic count_high(input int g);
		n = 0;
		repeat (2048) begin
			@(negedge clk);
			n += hs_pwm[g];
		end
	endtask
	// Cycles from one rising edge of a generator output to the next
	task automatic period_of(input int g);
		@(negedge clk);
		while (hs_pwm[g]) @(negedge clk);
		while (!hs_pwm[g]) @(negedge clk);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (hs_pwm[g]);
		while (!hs_pwm[g]) begin
			@(negedge clk);
			n++;
		end
	endtask
	// Scenarios
	task automatic t_reset();
		chk("mask", 17'h0_0140, {1'b0, int_mask});
		chk("bridge", 17'h0_0801, {1'b0, bridge_cfg});
		rdc("cfg", ADDR_PWM_CFG, 16'h0000);
		rdc("scratch", ADDR_SCRATCH, 16'h0000);
	endtask
	task automatic t_regs();
		host.wr(ADDR_PWM_CFG, 16'hfff9);
		rdc("cfg", ADDR_PWM_CFG, 16'h7ff1);
		host.wr(ADDR_INT_MASK, 16'hffff);
		host.wr(ADDR_SCRATCH, 16'ha5c3);
		pulse_restart();
		rdc("cfg", ADDR_PWM_CFG, 16'h7ff0);
		rdc("mask", ADDR_INT_MASK, 16'h01ff);
		rdc("scratch", ADDR_SCRATCH, 16'ha5c3);
		normal_mode = 1'b0;
		host.wr(ADDR_SCRATCH, 16'h0000);
		rdc("scratch", ADDR_SCRATCH, 16'h0000);
		normal_mode = 1'b1;
		rdc("scratch", ADDR_SCRATCH, 16'ha5c3);
		rdc("unmapped", 7'h7f, 16'h0000);
	endtask
	task automatic t_bridge();
		host.wr(ADDR_BRIDGE, 16'he000);
		chk("bridge", 17'h0_e000, {1'b0, bridge_cfg});
		chk("route", 17'h0_0028, {9'h000, bridge_route});
		host.wr(ADDR_BRIDGE, 16'h1f00);
		chk("bridge", 17'h0_1f00, {1'b0, bridge_cfg});
		chk("route", 17'h0_0014, {9'h000, bridge_route});
	endtask
	task automatic t_pwm();
		host.wr(ADDR_PWM_CFG, 16'h2000);
		host.wr(ADDR_PWM_CFG, 16'h5001);
		host.wr(ADDR_PWM_CFG, 16'h3ff2);
		host.wr(ADDR_PWM_CFG, 16'h0004);
		repeat (4200) @(posedge clk);
		count_high(0);
		chk("gen1", 17'h0_0400, 17'(n));
		count_high(1);
		chk("gen2", 17'h0_0200, 17'(n));
		count_high(2);
		chk("gen3", 17'h0_0800, 17'(n));
		count_high(3);
		chk("gen4", 17'h0_0000, 17'(n));
		period_of(0);
		chk("gen1 period", 17'h0_0800, 17'(n));
		period_of(1);
		chk("gen2 period", 17'h0_0400, 17'(n));
	endtask
	// Verdict
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	// Main sequence
	initial begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_regs();
		t_bridge();
		t_pwm();
		tally_and_finish();
	end
endmodule
